// ### include/eee_lpi_pkg.sv
// constants for the eee low power idle wake control block
// assumes a 25 MHz system clock and a 32-bit AXI4-Lite register port
package eee_lpi_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0]  IDX_RECOV_WAIT = 10'h0E6;
   localparam logic [9:0]  IDX_BUF_CTRL   = 10'h0E7;
   localparam logic [9:0]  IDX_PAGE_TX    = 10'h0E8;
   localparam int          ADDR_W         = 12;
   // field positions
   localparam int          CANCEL_BIT     = 7;
   localparam int          THR_MSB        = 5;
   localparam int          MORE_BIT       = 15;
   localparam int          MSG_BIT        = 13;
   localparam int          COMPLY_BIT     = 12;
   localparam int          TOG_BIT        = 11;
   localparam int          BUF_UNIT_LOG2  = 9;
   // reset values
   localparam logic [7:0]  RECOV_RST      = 8'h27;
   localparam logic [5:0]  THR_RST        = 6'h08;
   localparam logic        CANCEL_RST     = 1'b0;
   localparam logic        MORE_RST       = 1'b0;
   localparam logic        MSG_RST        = 1'b1;
   localparam logic        COMPLY_RST     = 1'b0;
   localparam logic        TOG_RST        = 1'b0;
   localparam logic [10:0] CODE_RST       = 11'h001;
   // timing
   localparam int          CLK_NS         = 40;
   localparam int          STEP_NS        = 640;
   localparam int          STEP_CYC       = (STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;
endpackage

// ### include/recov_if.sv
// handshake between the register block and the recovery timer
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface recov_if;
   logic       start;
   logic [7:0] count;
   logic       busy;
   modport ctl (output start, output count, input busy);
   modport tmr (input start, input count, output busy);
endinterface

// ### logic/recovery_timer.sv
// recovery wait timer: holds busy for count steps of 640 ns
// assumes start is a one-cycle pulse on clk_sys
`timescale 1ns/1ps
module recovery_timer
   import eee_lpi_pkg::*;
(
   input  wire logic clk_sys, // system clock
   input  wire logic rst,     // async reset, active high
   recov_if.tmr      rif      // start / count / busy
);
   logic [4:0]  div_r;
   logic [7:0]  steps_r;
   logic        busy_r;
   logic [12:0] hc_r;
   logic [7:0]  len_r;

   assign rif.busy = busy_r;

   // step countdown
   // divider restarts on every start with a nonzero count so the first step is a full one
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_r   <= 5'h00;
         steps_r <= 8'h00;
         busy_r  <= 1'b0;
      end else if (rif.start && rif.count != 8'h00) begin
         div_r   <= 5'h00;
         steps_r <= rif.count;
         busy_r  <= 1'b1;
      end else if (busy_r) begin
         if (div_r == 5'(STEP_CYC - 1)) begin
            div_r   <= 5'h00;
            steps_r <= steps_r - 8'h01;
            if (steps_r == 8'h01) begin
               busy_r <= 1'b0;
            end
         end else begin
            div_r <= div_r + 5'h01;
         end
      end
   end

   // helper for the length check
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hc_r  <= 13'h0000;
         len_r <= 8'h00;
      end else if (rif.start && rif.count != 8'h00) begin
         hc_r  <= 13'h0000;
         len_r <= rif.count;
      end else if (busy_r) begin
         hc_r <= hc_r + 13'h0001;
      end
   end

   recov_len_a: assert property (@(posedge clk_sys) disable iff (rst)
      $fell(busy_r) |-> hc_r == 13'(len_r) * 13'(STEP_CYC))
      else $error("recovery wait length wrong");
endmodule // recovery_timer

// ### logic/eee_lpi_wake_control.sv
// eee low power idle wake control with AXI4-Lite registers
// assumes all inputs synchronous to clk_sys; lpi_exit is a one-cycle pulse
`timescale 1ns/1ps
module eee_lpi_wake_control
   import eee_lpi_pkg::*;
#(
   parameter int PORTS = 2,  // source ports
   parameter int USE_W = 16  // buffer usage width in bits
)(
   input  wire logic                         clk_sys,       // system clock
   input  wire logic                         rst,           // async reset
   input  wire logic [ADDR_W-1:0]            s_axi_awaddr,  // write address
   input  wire logic                         s_axi_awvalid, // write addr valid
   output wire logic                         s_axi_awready, // write addr ready
   input  wire logic [31:0]                  s_axi_wdata,   // write data
   input  wire logic [3:0]                   s_axi_wstrb,   // byte enables
   input  wire logic                         s_axi_wvalid,  // write data valid
   output wire logic                         s_axi_wready,  // write data ready
   output logic      [1:0]                   s_axi_bresp,   // write response
   output logic                              s_axi_bvalid,  // response valid
   input  wire logic                         s_axi_bready,  // response ready
   input  wire logic [ADDR_W-1:0]            s_axi_araddr,  // read address
   input  wire logic                         s_axi_arvalid, // read addr valid
   output wire logic                         s_axi_arready, // read addr ready
   output logic      [31:0]                  s_axi_rdata,   // read data
   output logic      [1:0]                   s_axi_rresp,   // read response
   output logic                              s_axi_rvalid,  // read data valid
   input  wire logic                         s_axi_rready,  // read data ready
   input  wire logic                         lpi_exit,      // port 1 left idle
   output wire logic                         tx_hold_off,   // port 1 may not send
   input  wire logic [PORTS-1:0]             lpi_req_in,    // idle request per port
   input  wire logic [PORTS-1:0]             in_traffic,    // input traffic seen
   input  wire logic [PORTS-1:0][USE_W-1:0]  buf_usage,     // buffer bytes per port
   output logic      [PORTS-1:0]             lpi_req_out,   // idle request granted
   input  wire logic                         page_load,     // new next page loaded
   input  wire logic                         base_load,     // base page sent
   input  wire logic                         base_toggle,   // toggle bit of base page
   input  wire logic                         page_more,     // more pages follow
   input  wire logic                         page_msg,      // message page
   input  wire logic                         page_comply,   // able to comply
   input  wire logic [10:0]                  page_code      // code field
);
   recov_if rif();

   logic [7:0]        recov_wait_r;
   logic              cancel_en_r;
   logic [5:0]        buf_thr_r;
   logic              more_pages_follow_flag;
   logic              message_page_flag;
   logic              comply_acknowledge_flag;
   logic              toggle_r;
   logic [10:0]       code_r;
   logic              aw_hold_r;
   logic              w_hold_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0]       w_data_r;
   logic [3:0]        w_strb_r;
   logic              do_wr;
   logic [PORTS-1:0]  withdrawn_r;
   logic [PORTS-1:0]  over_thr;
   logic [USE_W-1:0]  thr_bytes;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
      hit = (a == ADDR_W'({idx, 2'b00}));
   endfunction

   // write path: address and data taken independently
   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
   assign do_wr         = aw_hold_r && w_hold_r && !s_axi_bvalid;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (do_wr) begin
         aw_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         w_hold_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (do_wr) begin
         w_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (hit(aw_addr_r, IDX_RECOV_WAIT) || hit(aw_addr_r, IDX_BUF_CTRL)
                          || hit(aw_addr_r, IDX_PAGE_TX)) ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         recov_wait_r <= RECOV_RST;
      end else if (do_wr && w_strb_r[0] && hit(aw_addr_r, IDX_RECOV_WAIT)) begin
         recov_wait_r <= w_data_r[7:0];
      end
   end

   // buffer load control; bit 6 stays zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cancel_en_r <= CANCEL_RST;
         buf_thr_r   <= THR_RST;
      end else if (do_wr && w_strb_r[0] && hit(aw_addr_r, IDX_BUF_CTRL)) begin
         cancel_en_r <= w_data_r[CANCEL_BIT];
         buf_thr_r   <= w_data_r[THR_MSB:0];
      end
   end

   // read path; the page word is read-only, writes to it are ignored
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (hit(s_axi_araddr, IDX_RECOV_WAIT)) begin
            s_axi_rdata <= {24'h000000, recov_wait_r};
         end else if (hit(s_axi_araddr, IDX_BUF_CTRL)) begin
            s_axi_rdata <= {24'h000000, cancel_en_r, 1'b0, buf_thr_r};
         end else if (hit(s_axi_araddr, IDX_PAGE_TX)) begin
            s_axi_rdata <= {16'h0000, more_pages_follow_flag, 1'b0, message_page_flag,
                            comply_acknowledge_flag, toggle_r, code_r};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_DECERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // recovery timer; zero count never sets busy
   assign rif.start   = lpi_exit;
   assign rif.count   = recov_wait_r;
   assign tx_hold_off = rif.busy;

   recovery_timer u_timer (
      .clk_sys (clk_sys),
      .rst     (rst),
      .rif     (rif)
   );

   // next-page transmit word captured from the negotiation engine
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         more_pages_follow_flag  <= MORE_RST;
         message_page_flag       <= MSG_RST;
         comply_acknowledge_flag <= COMPLY_RST;
         code_r                  <= CODE_RST;
      end else if (page_load) begin
         more_pages_follow_flag  <= page_more;
         message_page_flag       <= page_msg;
         comply_acknowledge_flag <= page_comply;
         code_r                  <= page_code;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         toggle_r <= TOG_RST;
      end else if (base_load) begin
         toggle_r <= base_toggle;
      end else if (page_load) begin
         toggle_r <= !toggle_r;
      end
   end

   assign thr_bytes = USE_W'({buf_thr_r, {BUF_UNIT_LOG2{1'b0}}});

   genvar p;
   generate
      for (p = 0; p < PORTS; p++) begin : g_port
         assign over_thr[p] = buf_usage[p] > thr_bytes;

         // withdrawal lasts until the request drops
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               withdrawn_r[p] <= 1'b0;
            end else if (!lpi_req_in[p]) begin
               withdrawn_r[p] <= 1'b0;
            end else if (cancel_en_r && in_traffic[p]) begin
               withdrawn_r[p] <= 1'b1;
            end
         end

         assign lpi_req_out[p] = lpi_req_in[p] && !over_thr[p] && !withdrawn_r[p]
                                 && !(cancel_en_r && in_traffic[p]);

         sequence traffic_cut;
            cancel_en_r && in_traffic[p] && lpi_req_in[p];
         endsequence
         cancel_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
            traffic_cut ##1 lpi_req_in[p] [*2] |-> !lpi_req_out[p])
            else $error("request not withdrawn on traffic");
         cancel_off_a: assert property (@(posedge clk_sys) disable iff (rst)
            (!cancel_en_r && lpi_req_in[p] && !over_thr[p] && !withdrawn_r[p])
            |-> lpi_req_out[p])
            else $error("request withdrawn while cancel disabled");
         buf_term_a: assert property (@(posedge clk_sys) disable iff (rst)
            (buf_usage[p] > USE_W'({buf_thr_r, 9'h000})) |-> !lpi_req_out[p])
            else $error("idle kept above buffer threshold");
      end
   endgenerate

   sequence exit_with_wait;
      lpi_exit && recov_wait_r != 8'h00;
   endsequence
   recov_start_a: assert property (@(posedge clk_sys) disable iff (rst)
      exit_with_wait |=> tx_hold_off [*8])
      else $error("transmit not held after idle exit");
   recov_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
      (lpi_exit && recov_wait_r == 8'h00 && !tx_hold_off) |=> !tx_hold_off)
      else $error("zero wait still held transmit");
   page_flags_a: assert property (@(posedge clk_sys) disable iff (rst)
      page_load |=> more_pages_follow_flag == $past(page_more)
                    && message_page_flag == $past(page_msg))
      else $error("page flags not captured");
   toggle_flip_a: assert property (@(posedge clk_sys) disable iff (rst)
      (page_load && !base_load) |=> toggle_r != $past(toggle_r))
      else $error("toggle did not invert");
   page_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && hit(s_axi_araddr, IDX_PAGE_TX))
      |=> s_axi_rvalid && s_axi_rdata[14] == 1'b0
          && s_axi_rdata[MORE_BIT] == $past(more_pages_follow_flag)
          && s_axi_rdata[MSG_BIT] == $past(message_page_flag)
          && s_axi_rdata[COMPLY_BIT] == $past(comply_acknowledge_flag))
      else $error("page word read wrong");
   bresp_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
endmodule // eee_lpi_wake_control

// ### tb/link_partner_model.sv
// link partner model: drives idle exit and the next-page stream into the block
// assumes it shares clk_sys with the block and that the bench calls its tasks
`timescale 1ns/1ps
module link_partner_model (
   input  wire logic        clk_sys,     // system clock
   output logic             lpi_exit,    // idle exit pulse
   output logic             page_load,   // next page loaded
   output logic             base_load,   // base page sent
   output logic             base_toggle, // base page toggle
   output logic             page_more,   // more pages follow
   output logic             page_msg,    // message page
   output logic             page_comply, // able to comply
   output logic [10:0]      page_code    // code field
);
   initial begin
      {lpi_exit, page_load, base_load, base_toggle} = 4'h0;
      {page_more, page_msg, page_comply} = 3'h0;
      page_code = 11'h000;
   end
   task automatic exit_idle();
      @(posedge clk_sys);
      lpi_exit <= 1'b1;
      @(posedge clk_sys);
      lpi_exit <= 1'b0;
   endtask
   task automatic send_base(input logic tog);
      @(posedge clk_sys);
      base_toggle <= tog;
      base_load   <= 1'b1;
      @(posedge clk_sys);
      base_load   <= 1'b0;
   endtask
   task automatic send_page(input logic more, msg, comply, input logic [10:0] code);
      @(posedge clk_sys);
      {page_more, page_msg, page_comply, page_code} <= {more, msg, comply, code};
      page_load <= 1'b1;
      @(posedge clk_sys);
      page_load <= 1'b0;
   endtask
endmodule // link_partner_model

// ### tb/eee_lpi_wake_control_tb_top.sv
// self-checking bench for the low power idle wake control block
// assumes register answers within 50 cycles and a 16-cycle recovery step
`timescale 1ns/1ps
module eee_lpi_wake_control_tb_top
   import eee_lpi_pkg::*;
;
   logic clk_sys = 1'b0, rst = 1'b1;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid, hold;
   logic [1:0] bresp, rresp, req_in = 2'h0, traffic = 2'h0, req_out;
   logic [1:0][15:0] usage = '0;
   logic lpi_exit, pg_ld, bs_ld, bs_tg, pg_more, pg_msg, pg_comply;
   logic [10:0] pg_code;
   int bad_count = 0, total_checks = 0;

   always #20 clk_sys = ~clk_sys;

   eee_lpi_wake_control u_dut (.clk_sys(clk_sys), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .lpi_exit(lpi_exit), .tx_hold_off(hold), .lpi_req_in(req_in), .in_traffic(traffic),
      .buf_usage(usage), .lpi_req_out(req_out), .page_load(pg_ld), .base_load(bs_ld),
      .base_toggle(bs_tg), .page_more(pg_more), .page_msg(pg_msg), .page_comply(pg_comply),
      .page_code(pg_code));

   link_partner_model u_partner (.clk_sys(clk_sys), .lpi_exit(lpi_exit), .page_load(pg_ld),
      .base_load(bs_ld), .base_toggle(bs_tg), .page_more(pg_more), .page_msg(pg_msg),
      .page_comply(pg_comply), .page_code(pg_code));

   task automatic final_report();
      if (bad_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic hung();
      bad_count++;
      $display("ERROR t=%0t register port did not answer", $time);
      final_report();
   endtask
   // ready is settled between the falling edge and the sampling rising edge
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      logic aw_go, w_go, b_go;
      r = 2'h0;
      @(posedge clk_sys);
      {awaddr, wdata, wstrb} <= {a, d, 4'hF};
      {awvalid, wvalid, bready} <= 3'h7;
      for (n = 0; n <= 50; n++) begin
         @(negedge clk_sys);
         aw_go = awvalid & awready;
         w_go = wvalid & wready;
         b_go = (bvalid === 1'b1);
         if (b_go) r = bresp;
         @(posedge clk_sys);
         if (aw_go) awvalid <= 1'b0;
         if (w_go) wvalid <= 1'b0;
         if (b_go) begin
            bready <= 1'b0;
            break;
         end
      end
      if (n > 50) hung();
   endtask
   task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ar_go, r_go;
      {d, r} = 34'h0;
      @(posedge clk_sys);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (n = 0; n <= 50; n++) begin
         @(negedge clk_sys);
         ar_go = arvalid & arready;
         r_go = (rvalid === 1'b1);
         if (r_go) {d, r} = {rdata, rresp};
         @(posedge clk_sys);
         if (ar_go) arvalid <= 1'b0;
         if (r_go) begin
            rready <= 1'b0;
            break;
         end
      end
      if (n > 50) hung();
   endtask
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask

   // register defaults, read-only and reserved places, unmapped addresses
   task automatic t_regs();
      logic [1:0] r;
      rd_chk(12'h398, 32'h27, RESP_OKAY);
      rd_chk(12'h39C, 32'h08, RESP_OKAY);
      rd_chk(12'h3A0, 32'h2001, RESP_OKAY);
      rd_chk(12'h004, 32'h0, RESP_DECERR);
      axi_wr(12'h004, 32'hFF, r);
      chk({30'h0, r}, {30'h0, RESP_DECERR});
      axi_wr(12'h3A0, 32'hFFFF, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rd_chk(12'h3A0, 32'h2001, RESP_OKAY);
      axi_wr(12'h39C, 32'hFF, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      rd_chk(12'h39C, 32'hBF, RESP_OKAY);
   endtask
   // hold-off length after idle exit, including a zero count
   task automatic t_recov(input logic [7:0] local_t, input logic [7:0] remote_t);
      logic [1:0] r;
      logic [7:0] n;
      int cnt;
      n = (local_t > remote_t) ? local_t : remote_t;
      axi_wr(12'h398, {24'h0, n}, r);
      rd_chk(12'h398, {24'h0, n}, RESP_OKAY);
      u_partner.exit_idle();
      cnt = 0;
      @(negedge clk_sys);
      while (hold === 1'b1 && cnt < 300) begin
         cnt++;
         @(negedge clk_sys);
      end
      chk(cnt, n * 16);
   endtask
   // threshold above 512-byte units and traffic cancel
   task automatic t_idle();
      logic [1:0] r;
      axi_wr(12'h39C, 32'h02, r);
      @(posedge clk_sys);
      {req_in, traffic} <= {2'h3, 2'h1};
      usage <= {16'd1025, 16'd1024};
      @(negedge clk_sys);
      chk(req_out, 2'h1);
      axi_wr(12'h39C, 32'h82, r);
      @(negedge clk_sys);
      chk(req_out, 2'h0);
      @(posedge clk_sys);
      {req_in, traffic} <= 4'h0;
      @(posedge clk_sys);
      req_in <= 2'h3;
      usage <= {16'd1024, 16'd1024};
      @(negedge clk_sys);
      chk(req_out, 2'h3);
   endtask
   // next-page flags and toggle across two pages
   task automatic t_page();
      u_partner.send_base(1'b1);
      u_partner.send_page(1'b1, 1'b0, 1'b1, 11'h155);
      rd_chk(12'h3A0, 32'h9155, RESP_OKAY);
      u_partner.send_page(1'b0, 1'b1, 1'b0, 11'h2AA);
      rd_chk(12'h3A0, 32'h2AAA, RESP_OKAY);
   endtask

   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_recov(8'h01, 8'h02);
      t_recov(8'h00, 8'h00);
      t_idle();
      t_page();
      final_report();
   end
endmodule // eee_lpi_wake_control_tb_top
